// File: sim/cli_host.sv
`timescale 1ns/1ps
// ****
// Host processor on the APB side
// ****
module cli_host (
	// Clock
	input wire logic pclk,
	// APB master
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [cli_pkg::ADDR_W-1:0] paddr,
	output logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h00000000;
	end

	// Released lines flip so a stale value cannot pass for a fresh one
	task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] data,
		output logic [31:0] rdata, output logic err);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= addr;
		pwdata <= data;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rdata = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		paddr <= ~addr;
		pwdata <= ~data;
	endtask

	task automatic idle(output logic [31:0] st);
		logic e;
		st = 32'hFFFFFFFF;
		while (st[cli_pkg::STATUS_BUSY_POS] !== 1'b0) xfer(1'b0, cli_pkg::OFF_STATUS, 32'h0, st, e);
	endtask

	// Every write waits for busy to clear first
	task automatic op(input logic wr, input logic [7:0] addr, input logic [7:0] b, output logic [31:0] r);
		logic e;
		logic [31:0] st;
		idle(st);
		xfer(wr, addr, {24'h0, b}, r, e);
		idle(st);
	endtask
endmodule

// File: sim/tb_top.sv
`timescale 1ns/1ps
// ****
// Decoder bench
// ****
module tb_top;
	localparam int EXEC = 8;
	logic pclk;
	logic presetn;
	logic psel;
	logic penable;
	logic pwrite;
	logic [7:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	cli_pkg::cli_cfg_t cfg;
	logic [6:0] shift_offset;
	logic [6:0] cursor_addr;
	logic glyph_selected;
	logic busy;
	int failures = 0;
	int cmp_count = 0;
	int cycles = 0;
	logic [31:0] r;
	logic e;
	logic [7:0] fc [4] = '{8'h3C, 8'h25, 8'h3A, 8'h37};
	logic [11:0] fe [4] = '{12'hE08, 12'h288, 12'hD08, 12'hD08};
	logic [7:0] sc [7] = '{8'h85, 8'h10, 8'h14, 8'h1C, 8'h18, 8'h18, 8'h03};
	logic [6:0] sp [7] = '{7'h05, 7'h04, 7'h05, 7'h05, 7'h05, 7'h05, 7'h00};
	logic [6:0] so [7] = '{7'h00, 7'h00, 7'h00, 7'h27, 7'h00, 7'h01, 7'h00};

	cli_decoder #(.EXEC_CYCLES(EXEC)) u_cli_decoder (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .cfg(cfg), .shift_offset(shift_offset),
		.cursor_addr(cursor_addr), .glyph_selected(glyph_selected), .busy(busy));
	cli_host u_cli_host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	task automatic close_out;
		$display("comparisons %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask

	always @(posedge pclk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			failures++;
			close_out();
		end
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			failures++;
			$display("ERROR %0t: got %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic ins(input logic [7:0] c);
		u_cli_host.op(1'b1, cli_pkg::OFF_INSTR, c, r);
	endtask

	task automatic dat(input logic wr, input logic [7:0] d);
		u_cli_host.op(wr, cli_pkg::OFF_DATA, d, r);
	endtask

	initial begin
		presetn = 1'b0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		chk(32'(cfg), 32'h808);
		chk({busy, glyph_selected, shift_offset, cursor_addr}, 32'h0);
		// Function set comes first; a repeat with the same width is dropped
		for (int i = 0; i < 4; i++) begin
			ins(fc[i]);
			chk(32'(cfg), 32'(fe[i]));
		end
		for (int i = 0; i < 8; i++) begin
			ins(8'h08 | 8'(i));
			chk({29'h0, cfg.display_on, cfg.cursor_on, cfg.blink_on}, 32'(i));
		end
		for (int i = 0; i < 4; i++) begin
			ins(8'h13 | 8'(i << 2));
			chk({30'h0, cfg.graphic_mode, cfg.power_on}, 32'(i));
		end
		ins(8'hA6);
		chk(32'(cursor_addr), 32'h26);
		ins(8'h06);
		chk({30'h0, cfg.step_up, cfg.shift_on_entry}, 32'h2);
		dat(1'b1, 8'h41);
		chk(32'(cursor_addr), 32'h27);
		dat(1'b1, 8'h42);
		chk({shift_offset, cursor_addr}, 32'h40);
		dat(1'b0, 8'h00);
		chk(32'(cursor_addr), 32'h41);
		ins(8'h04);
		dat(1'b1, 8'h43);
		chk(32'(cursor_addr), 32'h40);
		u_cli_host.idle(r);
		chk(r, 32'h40);
		ins(8'hA7);
		dat(1'b0, 8'h00);
		chk(r, 32'h42);
		for (int i = 0; i < 7; i++) begin
			ins(sc[i]);
			chk({shift_offset, cursor_addr}, {so[i], sp[i]});
		end
		ins(8'h07);
		dat(1'b1, 8'h44);
		chk({shift_offset, cursor_addr}, {7'h01, 7'h01});
		ins(8'h05);
		dat(1'b1, 8'h45);
		chk({shift_offset, cursor_addr}, {7'h00, 7'h00});
		ins(8'h7F);
		chk({glyph_selected, cursor_addr}, 32'hBF);
		ins(8'h06);
		dat(1'b1, 8'hA5);
		chk({shift_offset, cursor_addr}, 32'h0);
		ins(8'h7F);
		dat(1'b0, 8'h00);
		chk(r, 32'hA5);
		// Second instruction lands inside the busy window and must be dropped
		u_cli_host.xfer(1'b1, cli_pkg::OFF_INSTR, 32'h90, r, e);
		u_cli_host.xfer(1'b0, cli_pkg::OFF_STATUS, 32'h0, r, e);
		chk(32'(r[7]), 32'h1);
		u_cli_host.xfer(1'b1, cli_pkg::OFF_INSTR, 32'hA0, r, e);
		u_cli_host.idle(r);
		chk(r, 32'h10);
		u_cli_host.xfer(1'b0, 8'h10, 32'h0, r, e);
		chk({31'h0, e}, 32'h1);
		chk(r, 32'h0);
		u_cli_host.xfer(1'b0, cli_pkg::OFF_CONFIG, 32'h0, r, e);
		chk(r, 32'h00000D7B);
		close_out();
	end
endmodule

// File: verilog/cli_busy_timer.sv
`timescale 1ns/1ps
module cli_busy_timer #(
	parameter int CYCLES = cli_pkg::EXEC_CYCLES
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Control
	input wire logic start,
	output logic busy
);

	localparam int CW = $clog2(CYCLES + 1);
	localparam logic [CW-1:0] LOAD = CW'(CYCLES);

	logic [CW-1:0] count;
	wire logic [CW-1:0] next_count = start ? LOAD : ((count != '0) ? count - CW'(1) : count);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count <= '0;
			busy <= 1'b0;
		end else begin
			count <= next_count;
			busy <= (next_count != '0);
		end
	end

endmodule

// File: verilog/cli_decoder.sv
`timescale 1ns/1ps
// Behaviour
// - Return home (0000001x) loads text address 0 and undoes any display shift
// - After return home the cursor sits at the left edge of line one
// - Entry mode 000001xx: bit 1 step direction, bit 0 shift on entry
// - Step up: each text access adds 1 to pointer, cursor right
// - Step down: each text access subtracts 1 from pointer, cursor left
// - Shift on entry moves display right when stepping down, left when up
// - Display control 00001xxx: bit 2 display, bit 1 cursor, bit 0 blink
// - Shift 0001xx00: cursor left, cursor right, display left, display right
// - Two-line cursor wraps to line two after fortieth position of line one
// - Display shifts move both lines together, horizontally only
// - Display-only shift leaves the address pointer unchanged
// - Shift group with low bits 11: bit 3 selects graphic mode
// - In that variant bit 2 switches the internal power converter
// - Function set 001xxxxx: bit 4 selects 8-bit or 4-bit transfers
// - Function set bit 3 selects two-line or one-line display
// - Function set bit 2 selects the taller or shorter font
// - Function set bits 1:0 select glyph table, reset value 00
// - Set glyph address loads six bits; data then goes to glyph RAM
// - Set text address loads any seven bits, with no check against the line-mode ranges
// - Status read gives busy on bit 7, pointer below; busy refuses instructions
// - Display bit turns display on, cursor bit shows cursor, blink bit blinks
// - Each data write to either RAM steps the pointer by entry mode
// - Busy reads 1 while executing, 0 once a new instruction can be accepted
module cli_decoder #(
	parameter int EXEC_CYCLES = cli_pkg::EXEC_CYCLES
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [cli_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Display state
	output cli_pkg::cli_cfg_t cfg,
	output logic [6:0] shift_offset,
	output logic [6:0] cursor_addr,
	output logic glyph_selected,
	output logic busy
);

	// ************************************************************
	// Helpers
	// ************************************************************
	// Next pointer value for one step; text addresses follow the line layout
	function automatic logic [6:0] step_addr(input logic [6:0] a, input logic up, input logic two,
			input logic glyph);
		logic [6:0] r;
		r = up ? a + 7'h01 : a - 7'h01;
		if (glyph) begin
			r = {1'b0, r[5:0]};
		end else if (!two) begin
			if (up && a >= cli_pkg::ONE_LINE_END) begin
				r = cli_pkg::HOME_ADDR;
			end else if (!up && a == cli_pkg::HOME_ADDR) begin
				r = cli_pkg::ONE_LINE_END;
			end
		end else begin
			if (up && a == cli_pkg::LINE1_END) begin
				r = cli_pkg::LINE2_START;
			end else if (up && a >= cli_pkg::LINE2_END) begin
				r = cli_pkg::HOME_ADDR;
			end else if (!up && a == cli_pkg::LINE2_START) begin
				r = cli_pkg::LINE1_END;
			end else if (!up && a == cli_pkg::HOME_ADDR) begin
				r = cli_pkg::LINE2_END;
			end
		end
		return r;
	endfunction

	// One display shift; the offset counts left shifts modulo the line length
	function automatic logic [6:0] shift_by_one(input logic [6:0] off, input logic left, input logic two);
		logic [6:0] len;
		logic [6:0] r;
		len = two ? cli_pkg::LINE_LEN_TWO : cli_pkg::LINE_LEN_ONE;
		if (left) begin
			r = (off + 7'h01 >= len) ? 7'h00 : off + 7'h01;
		end else begin
			r = (off == 7'h00 || off >= len) ? len - 7'h01 : off - 7'h01;
		end
		return r;
	endfunction

	// ************************************************************
	// Storage
	// ************************************************************
	logic [7:0] text_ram [cli_pkg::TEXT_DEPTH];
	logic [7:0] glyph_ram [cli_pkg::GLYPH_DEPTH];
	logic [6:0] address_pointer;
	logic fset_done;

	// ************************************************************
	// Bus decode
	// ************************************************************
	wire logic setup = psel && !penable;
	wire logic take = psel && penable && pready;
	wire logic hit_instr = (paddr == cli_pkg::OFF_INSTR);
	wire logic hit_data = (paddr == cli_pkg::OFF_DATA);
	wire logic hit_status = (paddr == cli_pkg::OFF_STATUS);
	wire logic hit_config = (paddr == cli_pkg::OFF_CONFIG);
	wire logic mapped = hit_instr || hit_data || hit_status || hit_config;
	wire logic [7:0] b = pwdata[7:0];

	// Anything that executes is refused while busy
	wire logic instr_take = take && pwrite && hit_instr && !busy;
	wire logic data_take = take && hit_data && !busy;
	wire logic data_wr = data_take && pwrite;

	// ************************************************************
	// Instruction decode
	// ************************************************************
	wire logic is_home = (b[7:1] == 7'h01);
	wire logic is_entry = (b[7:2] == 6'h01);
	wire logic is_disp = (b[7:3] == 5'h01);
	wire logic is_shift = (b[7:4] == 4'h1) && (b[1:0] == 2'h0);
	wire logic is_mode = (b[7:4] == 4'h1) && (b[1:0] == 2'h3);
	wire logic is_fset = (b[7:5] == 3'h1);
	wire logic is_gaddr = (b[7:6] == 2'h1);
	wire logic is_taddr = b[7];
	// Once configured, function set only runs on a change of bus width
	wire logic fset_ok = is_fset && (!fset_done || b[4] != cfg.bus_width);
	wire logic disp_shift = is_shift && b[3];
	wire logic cur_shift = is_shift && !b[3];

	// ************************************************************
	// Next state
	// ************************************************************
	wire logic [6:0] entry_step = step_addr(address_pointer, cfg.step_up, cfg.two_line,
			glyph_selected);
	wire logic [6:0] cur_step = step_addr(address_pointer, b[2], cfg.two_line, 1'b0);
	wire logic [6:0] entry_shift = shift_by_one(shift_offset, cfg.step_up, cfg.two_line);
	wire logic [6:0] cmd_shift = shift_by_one(shift_offset, !b[2], cfg.two_line);

	logic [6:0] next_pointer;
	logic [6:0] next_offset;
	always_comb begin
		next_pointer = address_pointer;
		next_offset = shift_offset;
		if (instr_take) begin
			if (is_home) begin
				next_pointer = cli_pkg::HOME_ADDR;
				next_offset = 7'h00;
			end else if (cur_shift) begin
				next_pointer = cur_step;
			end else if (disp_shift) begin
				next_offset = cmd_shift;
			end else if (is_gaddr) begin
				next_pointer = {1'b0, b[5:0]};
			end else if (is_taddr) begin
				next_pointer = b[6:0];
			end
		end else if (data_take) begin
			next_pointer = entry_step;
			if (cfg.shift_on_entry && !glyph_selected) begin
				next_offset = entry_shift;
			end
		end
	end

	// ************************************************************
	// Settings
	// ************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg <= cli_pkg::cli_cfg_t'(cli_pkg::CFG_RST);
			fset_done <= 1'b0;
			glyph_selected <= 1'b0;
		end else if (instr_take) begin
			if (is_entry) begin
				cfg.step_up <= b[1];
				cfg.shift_on_entry <= b[0];
			end
			if (is_disp) begin
				cfg.display_on <= b[2];
				cfg.cursor_on <= b[1];
				cfg.blink_on <= b[0];
			end
			if (is_mode) begin
				cfg.graphic_mode <= b[3];
				cfg.power_on <= b[2];
			end
			if (fset_ok) begin
				cfg.bus_width <= b[4];
				cfg.two_line <= b[3];
				cfg.tall_font <= b[2];
				cfg.glyph_table_hi <= b[1];
				cfg.glyph_table_lo <= b[0];
				fset_done <= 1'b1;
			end
			if (is_gaddr) begin
				glyph_selected <= 1'b1;
			end else if (is_taddr || is_home) begin
				glyph_selected <= 1'b0;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			address_pointer <= cli_pkg::HOME_ADDR;
			cursor_addr <= cli_pkg::HOME_ADDR;
			shift_offset <= 7'h00;
		end else begin
			address_pointer <= next_pointer;
			cursor_addr <= next_pointer;
			shift_offset <= next_offset;
		end
	end

	// RAM is not reset; contents survive return home and shifts
	always_ff @(posedge pclk) begin
		if (data_wr && glyph_selected) begin
			glyph_ram[address_pointer[5:0]] <= b;
		end
		if (data_wr && !glyph_selected) begin
			text_ram[address_pointer] <= b;
		end
	end

	// ************************************************************
	// Execution timer
	// ************************************************************
	cli_busy_timer #(
		.CYCLES(EXEC_CYCLES)
	) u_timer (
		.pclk(pclk),
		.presetn(presetn),
		.start(instr_take || data_take),
		.busy(busy)
	);

	// ************************************************************
	// APB answer: no wait state, read data captured in setup
	// ************************************************************
	wire logic [7:0] ram_byte = glyph_selected ? glyph_ram[address_pointer[5:0]] : text_ram[address_pointer];
	wire logic [31:0] status_word = {24'h000000, busy, address_pointer};
	wire logic [31:0] config_word = {7'h00, glyph_selected, 1'b0, shift_offset, 4'h0, cfg};
	wire logic [31:0] read_mux = hit_data ? {24'h000000, ram_byte} :
			hit_status ? status_word :
			hit_config ? config_word : 32'h00000000;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end else begin
			pready <= setup;
			pslverr <= setup && !mapped;
			if (setup) begin
				prdata <= pwrite ? 32'h00000000 : read_mux;
			end
		end
	end

	// ************************************************************
	// Checks
	// ************************************************************
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	a_home_clears: assert property (instr_take && is_home |=> address_pointer == 7'h00 && shift_offset == 7'h00)
		else $error("return home did not clear pointer and shift");
	a_busy_after_take: assert property (instr_take |=> busy)
		else $error("busy not raised after an instruction");
	a_busy_refuses: assert property (take && pwrite && hit_instr && busy |=> $stable(cfg))
		else $error("instruction accepted while busy");
	a_step_up_one: assert property (data_take && cfg.step_up && !glyph_selected && (cfg.two_line
			? (address_pointer != 7'h27 && address_pointer < 7'h67) : address_pointer < 7'h4F)
			|=> address_pointer == $past(address_pointer) + 7'h01)
		else $error("pointer did not step up by one");
	a_step_down_one: assert property (data_take && !cfg.step_up && !glyph_selected
			&& address_pointer != 7'h00 && !(cfg.two_line && address_pointer == 7'h40)
			|=> address_pointer == $past(address_pointer) - 7'h01)
		else $error("pointer did not step down by one");
	a_line_wrap: assert property (data_take && cfg.step_up && cfg.two_line && !glyph_selected
			&& address_pointer == 7'h27 |=> address_pointer == 7'h40)
		else $error("two-line wrap missed");
	a_shift_keeps_ptr: assert property (instr_take && disp_shift |=> $stable(address_pointer)
			&& shift_offset != $past(shift_offset))
		else $error("display shift disturbed the pointer");
	a_fset_lock: assert property (instr_take && is_fset && fset_done && b[4] == cfg.bus_width
			|=> $stable(cfg))
		else $error("function set ran without a width change");
	a_status_word: assert property (setup && !pwrite && hit_status |=> prdata[7] == $past(busy)
			&& prdata[6:0] == $past(address_pointer))
		else $error("status read does not show busy and pointer");
	a_busy_clears: assert property ($rose(busy) |-> ##[1:16] !busy)
		else $error("busy did not clear");
	a_entry_bits: assert property (instr_take && is_entry
			|=> {cfg.step_up, cfg.shift_on_entry} == $past(pwdata[1:0]))
		else $error("entry mode bits not stored");
	a_disp_bits: assert property (instr_take && is_disp
			|=> {cfg.display_on, cfg.cursor_on, cfg.blink_on} == $past(pwdata[2:0]))
		else $error("display control bits not stored");
	a_mode_bits: assert property (instr_take && is_mode
			|=> {cfg.graphic_mode, cfg.power_on} == $past(pwdata[3:2]))
		else $error("mode and power bits not stored");
	a_fset_bits: assert property (instr_take && fset_ok
			|=> {cfg.bus_width, cfg.two_line, cfg.tall_font, cfg.glyph_table_hi, cfg.glyph_table_lo} == $past(pwdata[4:0]))
		else $error("function set bits not stored");
	a_glyph_addr: assert property (instr_take && is_gaddr
			|=> glyph_selected && address_pointer == {1'b0, $past(pwdata[5:0])})
		else $error("glyph address not loaded");
	a_text_addr: assert property (instr_take && is_taddr
			|=> !glyph_selected && address_pointer == $past(pwdata[6:0]))
		else $error("text address not loaded");
	a_cursor_right: assert property (instr_take && cur_shift && b[2] && address_pointer < 7'h27
			|=> address_pointer == $past(address_pointer) + 7'h01)
		else $error("cursor right did not add one");
	a_cursor_left: assert property (instr_take && cur_shift && !b[2] && address_pointer != 7'h00
			&& address_pointer < 7'h40 |=> address_pointer == $past(address_pointer) - 7'h01)
		else $error("cursor left did not subtract one");
	a_entry_left: assert property (data_take && cfg.shift_on_entry && cfg.step_up && !glyph_selected
			&& shift_offset < 7'h27 |=> shift_offset == $past(shift_offset) + 7'h01)
		else $error("entry shift did not move display left");
	a_entry_right: assert property (data_take && cfg.shift_on_entry && !cfg.step_up && !glyph_selected
			&& shift_offset != 7'h00 && shift_offset < 7'h28 |=> shift_offset == $past(shift_offset) - 7'h01)
		else $error("entry shift did not move display right");
	a_no_entry_shift: assert property (data_take && !cfg.shift_on_entry
			|=> $stable(shift_offset))
		else $error("display shifted with shift on entry off");
	a_home_cursor: assert property (instr_take && is_home
			|=> cursor_addr == cli_pkg::HOME_ADDR)
		else $error("cursor not at left edge after return home");
	a_shift_range: assert property (instr_take && disp_shift && cfg.two_line
			|=> shift_offset < 7'h28)
		else $error("two-line shift left the line length");
	a_glyph_step: assert property (data_take && glyph_selected && cfg.step_up
			|=> address_pointer == {1'b0, $past(address_pointer[5:0]) + 6'h01})
		else $error("glyph pointer did not step within six bits");

endmodule

// File: verilog/cli_pkg.sv
package cli_pkg;

	// ************************************************************
	// Register map (byte addresses, one word each)
	// ************************************************************
	localparam int ADDR_W = 8;
	localparam logic [7:0] OFF_INSTR = 8'h00;
	localparam logic [7:0] OFF_DATA = 8'h04;
	localparam logic [7:0] OFF_STATUS = 8'h08;
	localparam logic [7:0] OFF_CONFIG = 8'h0C;

	// ************************************************************
	// Field positions
	// ************************************************************
	localparam int STATUS_BUSY_POS = 7;
	localparam int CONFIG_SHIFT_LSB = 16;
	localparam int CONFIG_GLYPH_SEL_POS = 24;

	// ************************************************************
	// Address ranges of the shared pointer
	// ************************************************************
	localparam logic [6:0] HOME_ADDR = 7'h00;
	localparam logic [6:0] ONE_LINE_END = 7'h4F;
	localparam logic [6:0] LINE1_END = 7'h27;
	localparam logic [6:0] LINE2_START = 7'h40;
	localparam logic [6:0] LINE2_END = 7'h67;
	localparam logic [6:0] LINE_LEN_TWO = 7'h28;
	localparam logic [6:0] LINE_LEN_ONE = 7'h50;
	localparam int TEXT_DEPTH = 128;
	localparam int GLYPH_DEPTH = 64;

	// ************************************************************
	// Execution time
	// ************************************************************
	localparam int CLK_PERIOD_NS = 10;
	localparam int EXEC_TIME_NS = 40;
	localparam int EXEC_CYCLES_RAW = (EXEC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int EXEC_CYCLES = (EXEC_CYCLES_RAW < 1) ? 1 : EXEC_CYCLES_RAW;

	// ************************************************************
	// Settings held by the decoder
	// ************************************************************
	typedef struct packed {
		logic bus_width;
		logic two_line;
		logic tall_font;
		logic glyph_table_hi;
		logic glyph_table_lo;
		logic display_on;
		logic cursor_on;
		logic blink_on;
		logic step_up;
		logic shift_on_entry;
		logic graphic_mode;
		logic power_on;
	} cli_cfg_t;

	// 8-bit bus, increment, everything else off, glyph table 00
	localparam logic [11:0] CFG_RST = 12'h808;

endpackage
